// File: hdl/lcc_pkg.sv
// ****************************************************************
// Shared constants for the logic cell cluster group
// ****************************************************************
package lcc_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int CELLS_PER_CLUSTER = 10;
  localparam int CLUSTERS_PER_GROUP = 4;
  // Carry hops skip one cluster: even to even, odd to odd
  localparam int CHAIN_SKIP = 2;

  // ****************************************************************
  // Lookup table layout
  // ****************************************************************
  localparam int LUT4_BITS = 16;
  localparam int LUT3_BITS = 8;
  // Arithmetic mode: sum table low half, carry table high half
  localparam int SUM_LUT_LSB = 0;
  localparam int CARRY_LUT_LSB = 8;

  // ****************************************************************
  // Selector encodings
  // ****************************************************************
  localparam logic OUT_SEL_LUT = 1'h0;
  localparam logic OUT_SEL_REG = 1'h1;
  localparam logic IN3_SEL_DATA = 1'h0;
  localparam logic IN3_SEL_CARRY = 1'h1;
  localparam logic REG_SRC_LUT = 1'h0;
  localparam logic REG_SRC_PACKED = 1'h1;
  localparam logic CASC_AND = 1'h0;
  localparam logic CASC_OR = 1'h1;
  localparam logic MODE_NORMAL = 1'h0;
  localparam logic MODE_ARITH = 1'h1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic CELL_REG_RST = 1'h0;

endpackage : lcc_pkg

// File: hdl/lcc_cluster_group.sv
// Notes on behaviour
// - Each cell has two outputs, each selecting table result or register.
// - Packing: one output carries the table, the other an unrelated register.
// - Registered and unregistered table results are visible at once.
// - Carry and cascade chains link cells 1..10 and continue across clusters.
// - Incoming carry feeds the cell's table and the next carry stage.
// - Chains beyond ten cells hop even to even and odd to odd clusters.
// - An n-bit adder uses n+1 cells; the extra cell outputs final carry.
// - Adder register may be bypassed or hold the sum as accumulator.
// - Carry-out goes straight to the next bit's carry input.
// - Normal mode uses a four-input table; third input is data or carry.
// - Normal mode combines table result with incoming cascade into cascade-out.
// - Normal mode cells support register packing.
// - Arithmetic mode splits into a function table and a carry table.
// - Function table takes carry, operand a and b; gives sum.
// - Carry table uses the same three inputs to make carry-out.
// - Arithmetic mode may use the cascade chain alongside the carry chain.
// - Cascade chain builds wide functions from per-cell partial results.
`timescale 1ns/1ns

// ****************************************************************
// One logic cell
// ****************************************************************
module lcc_cell (
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  input  wire logic                         cell_clr,
  input  wire logic                         cell_ena,
  input  wire logic                         arith_mode,
  input  wire logic                         in3_sel,
  input  wire logic                         reg_src_sel,
  input  wire logic                         out0_sel,
  input  wire logic                         out1_sel,
  input  wire logic                         casc_op,
  input  wire logic                         casc_use,
  input  wire logic [lcc_pkg::LUT4_BITS-1:0] lut_mask,
  input  wire logic                         operand_a_in,
  input  wire logic                         operand_b_in,
  input  wire logic                         third_data_in,
  input  wire logic                         fourth_data_in,
  input  wire logic                         carry_in,
  input  wire logic                         casc_in,
  output logic                              carry_out,
  output logic                              casc_out,
  output logic                              lut_comb,
  output logic                              reg_q,
  output logic                              out0,
  output logic                              out1
);

  logic       in3;
  logic [3:0] idx4;
  logic [2:0] idx3;
  logic       lut4_res;
  logic       sum_res;
  logic       reg_d;

  // Third table input picked at configuration time
  assign in3 = (in3_sel == lcc_pkg::IN3_SEL_CARRY) ? carry_in : third_data_in;
  assign idx4 = {fourth_data_in, in3, operand_b_in, operand_a_in};

  // Four-input table for normal mode
  assign lut4_res = lut_mask[idx4];

  // Arithmetic tables share carry, a and b
  assign idx3 = {carry_in, operand_b_in, operand_a_in};
  assign sum_res = lut_mask[lcc_pkg::SUM_LUT_LSB + int'(idx3)];

  // Carry only ripples in arithmetic mode; normal mode passes it on
  assign carry_out = (arith_mode == lcc_pkg::MODE_ARITH)
                   ? lut_mask[lcc_pkg::CARRY_LUT_LSB + int'(idx3)]
                   : carry_in;

  assign lut_comb = (arith_mode == lcc_pkg::MODE_ARITH) ? sum_res : lut4_res;

  // Cascade combine; unused cascade passes the table result unchanged
  always_comb
  begin
    if (!casc_use)
      casc_out = lut_comb;
    else if (casc_op == lcc_pkg::CASC_OR)
      casc_out = lut_comb | casc_in;
    else
      casc_out = lut_comb & casc_in;
  end

  // Packed register takes an unrelated input instead of the table
  assign reg_d = (reg_src_sel == lcc_pkg::REG_SRC_PACKED)
               ? fourth_data_in : lut_comb;

  // Cell register: async clear, sync reset, enabled load
  always_ff @(posedge core_clk or posedge cell_clr)
  begin
    if (cell_clr)
      reg_q <= lcc_pkg::CELL_REG_RST;
    else if (srst)
      reg_q <= lcc_pkg::CELL_REG_RST;
    else if (cell_ena)
      reg_q <= reg_d;
  end

  // Each output independently picks table or register
  assign out0 = (out0_sel == lcc_pkg::OUT_SEL_REG) ? reg_q : lut_comb;
  assign out1 = (out1_sel == lcc_pkg::OUT_SEL_REG) ? reg_q : lut_comb;

endmodule : lcc_cell

// ****************************************************************
// Cluster group: cells joined by carry and cascade chains
// ****************************************************************
module lcc_cluster_group #(
  parameter int CELLS    = lcc_pkg::CELLS_PER_CLUSTER,
  parameter int CLUSTERS = lcc_pkg::CLUSTERS_PER_GROUP,
  localparam int N       = CELLS * CLUSTERS,
  localparam int LW      = lcc_pkg::LUT4_BITS
) (
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic [N-1:0]        cell_clr,
  input  wire logic [N-1:0]        cell_ena,
  input  wire logic [N-1:0]        arith_mode,
  input  wire logic [N-1:0]        in3_sel,
  input  wire logic [N-1:0]        reg_src_sel,
  input  wire logic [N-1:0]        out0_sel,
  input  wire logic [N-1:0]        out1_sel,
  input  wire logic [N-1:0]        casc_op,
  input  wire logic [N-1:0]        casc_use,
  input  wire logic [N*LW-1:0]     lut_mask,
  input  wire logic [N-1:0]        operand_a_in,
  input  wire logic [N-1:0]        operand_b_in,
  input  wire logic [N-1:0]        third_data_in,
  input  wire logic [N-1:0]        fourth_data_in,
  input  wire logic [1:0]          group_carry_in,
  input  wire logic [1:0]          group_casc_in,
  output logic [1:0]               group_carry_out,
  output logic [1:0]               group_casc_out,
  output logic [N-1:0]             lut_comb,
  output logic [N-1:0]             reg_q,
  output logic [N-1:0]             out0,
  output logic [N-1:0]             out1
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Skip routing needs at least one cluster per parity lane
  if (CELLS < 1 || CLUSTERS < lcc_pkg::CHAIN_SKIP)
  begin : g_bad_size
    $error("lcc_cluster_group: CELLS or CLUSTERS too small");
  end

  // ****************************************************************
  // Chain wiring
  // ****************************************************************
  logic [N-1:0] cin;
  logic [N-1:0] cout;
  logic [N-1:0] kin;
  logic [N-1:0] kout;

  // Cell 0 of a cluster takes the last cell of the cluster two back;
  // skipping keeps chains off neighbouring rows for easier fitting.
  for (genvar k = 0; k < CLUSTERS; k++)
  begin : g_cluster
    for (genvar i = 0; i < CELLS; i++)
    begin : g_cell
      localparam int J = k * CELLS + i;
      if (i > 0)
      begin : g_in_cluster
        // Direct neighbour link, no general routing
        assign cin[J] = cout[J-1];
        assign kin[J] = kout[J-1];
      end
      else if (k >= lcc_pkg::CHAIN_SKIP)
      begin : g_hop
        // Even to even, odd to odd cluster
        assign cin[J] = cout[J - lcc_pkg::CHAIN_SKIP * CELLS + CELLS - 1];
        assign kin[J] = kout[J - lcc_pkg::CHAIN_SKIP * CELLS + CELLS - 1];
      end
      else
      begin : g_entry
        // Two chain lanes enter the group, one per parity
        assign cin[J] = group_carry_in[k];
        assign kin[J] = group_casc_in[k];
      end

      lcc_cell u_cell (
        .core_clk       (core_clk),
        .srst           (srst),
        .cell_clr       (cell_clr[J]),
        .cell_ena       (cell_ena[J]),
        .arith_mode     (arith_mode[J]),
        .in3_sel        (in3_sel[J]),
        .reg_src_sel    (reg_src_sel[J]),
        .out0_sel       (out0_sel[J]),
        .out1_sel       (out1_sel[J]),
        .casc_op        (casc_op[J]),
        .casc_use       (casc_use[J]),
        .lut_mask       (lut_mask[J*LW +: LW]),
        .operand_a_in   (operand_a_in[J]),
        .operand_b_in   (operand_b_in[J]),
        .third_data_in  (third_data_in[J]),
        .fourth_data_in (fourth_data_in[J]),
        .carry_in       (cin[J]),
        .casc_in        (kin[J]),
        .carry_out      (cout[J]),
        .casc_out       (kout[J]),
        .lut_comb       (lut_comb[J]),
        .reg_q          (reg_q[J]),
        .out0           (out0[J]),
        .out1           (out1[J])
      );
    end
  end

  // ****************************************************************
  // Group chain exits
  // ****************************************************************
  // Last cluster of each parity lane drives the group's chain outputs.
  // A final carry for general routing is taken instead by an extra cell
  // in arithmetic mode whose sum table copies carry_in (mask 0xF0).
  for (genvar p = 0; p < 2; p++)
  begin : g_exit
    localparam int LAST = ((CLUSTERS - 1 - p) / 2) * 2 + p;
    assign group_carry_out[p] = cout[LAST*CELLS + CELLS - 1];
    assign group_casc_out[p]  = kout[LAST*CELLS + CELLS - 1];
  end

endmodule : lcc_cluster_group

// File: verification/lcc_neighbour.sv
`timescale 1ns/1ns
// ****
// Upstream group feeding the chain entries
// ****
module lcc_neighbour (
  input  wire logic [1:0] carry_drv,
  input  wire logic [1:0] casc_drv,
  output logic [1:0]      group_carry_in,
  output logic [1:0]      group_casc_in
);
  // Dedicated chain wires, so no routing hop or delay
  assign group_carry_in = carry_drv;
  assign group_casc_in = casc_drv;
endmodule : lcc_neighbour

// File: verification/lcc_cluster_group_checker.sv
`timescale 1ns/1ns
// ****
// Port checks of the cluster group
// ****
module lcc_cluster_group_checker #(
  parameter int CELLS    = lcc_pkg::CELLS_PER_CLUSTER,
  parameter int CLUSTERS = lcc_pkg::CLUSTERS_PER_GROUP,
  localparam int N       = CELLS * CLUSTERS,
  localparam int LW      = lcc_pkg::LUT4_BITS
) (
  input wire logic            core_clk,
  input wire logic            srst,
  input wire logic [N-1:0]    cell_clr,
  input wire logic [N-1:0]    cell_ena,
  input wire logic [N-1:0]    arith_mode,
  input wire logic [N-1:0]    reg_src_sel,
  input wire logic [N-1:0]    out0_sel,
  input wire logic [N-1:0]    out1_sel,
  input wire logic [N*LW-1:0] lut_mask,
  input wire logic [N-1:0]    operand_a_in,
  input wire logic [N-1:0]    operand_b_in,
  input wire logic [N-1:0]    fourth_data_in,
  input wire logic [1:0]      group_carry_in,
  input wire logic [N-1:0]    lut_comb,
  input wire logic [N-1:0]    reg_q,
  input wire logic [N-1:0]    out0,
  input wire logic [N-1:0]    out1
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [N-1:0] ldl_q, ldp_q, lut_q, d4_q;
  // Load causes at the last edge; clear is async, so it masks
  always_ff @(posedge core_clk)
  begin
    ldl_q <= cell_ena & ~reg_src_sel & ~cell_clr;
    ldp_q <= cell_ena & reg_src_sel & ~cell_clr;
    lut_q <= lut_comb;
    d4_q  <= fourth_data_in;
  end
  // Output muxes, register timing and chain entries
  out0_mux_a: assert property (out0 == ((out0_sel & reg_q) | (~out0_sel & lut_comb)))
    else $error("out0 select wrong");
  out1_mux_a: assert property (out1 == ((out1_sel & reg_q) | (~out1_sel & lut_comb)))
    else $error("out1 select wrong");
  reg_hold_a:
    assert property (!$past(srst) |-> ((reg_q ^ $past(reg_q)) & ~$past(cell_ena)
      & ~$past(cell_clr) & ~cell_clr) == '0) else $error("register moved while held");
  rst_clear_a: assert property ($fell(srst) |-> reg_q == '0)
    else $error("register not cleared by reset");
  lut_load_a:
    assert property (!$past(srst) |-> ((reg_q ^ lut_q) & ldl_q & ~cell_clr) == '0)
    else $error("table result not loaded");
  pack_load_a:
    assert property (!$past(srst) |-> ((reg_q ^ d4_q) & ldp_q & ~cell_clr) == '0)
    else $error("packed input not loaded");
  arith_sum_a:
    assert property (arith_mode[0] |-> lut_comb[0]
      == lut_mask[{group_carry_in[0], operand_b_in[0], operand_a_in[0]}]) else $error("sum wrong");
  odd_entry_a:
    assert property (arith_mode[CELLS] |-> lut_comb[CELLS] == lut_mask[CELLS * LW
      + {group_carry_in[1], operand_b_in[CELLS], operand_a_in[CELLS]}]) else $error("odd entry");
endmodule : lcc_cluster_group_checker

bind lcc_cluster_group lcc_cluster_group_checker #(.CELLS(CELLS), .CLUSTERS(CLUSTERS))
  lcc_cluster_group_checker_inst (.*);

// File: verification/lcc_cluster_group_test.sv
`timescale 1ns/1ns
// ****
// Random configurations against a chain reference model
// ****
module lcc_cluster_group_test;
  localparam int CE = 3;
  localparam int CL = 4;
  localparam int N  = CE * CL;
  typedef struct packed {
    logic [N-1:0] lut;
    logic [N-1:0] r;
    logic [N-1:0] o0;
    logic [N-1:0] o1;
    logic [1:0]   co;
    logic [1:0]   cs;
  } lcc_note_s;
  logic            core_clk, srst, c, s;
  logic [N-1:0]    clr, ena, ar, i3, src, s0, s1, op, uc, a, b, d3, d4;
  logic [N-1:0]    lut, rq, o0, o1, ereg, nd, el;
  logic [N*16-1:0] msk;
  logic [1:0]      cin, csin, gci, gcsi, gco, gcso, eco, ecs;
  logic [15:0]     m;
  logic [2:0]      x;
  int              j;
  lcc_note_s       n;
  lcc_note_s       q[$];
  int              bad_count = 0;
  int              total_checks = 0;

  lcc_neighbour lcc_neighbour_inst (.carry_drv(cin), .casc_drv(csin),
    .group_carry_in(gci), .group_casc_in(gcsi));
  lcc_cluster_group #(.CELLS(CE), .CLUSTERS(CL)) lcc_cluster_group_inst (.core_clk(core_clk),
    .srst(srst), .cell_clr(clr), .cell_ena(ena), .arith_mode(ar), .in3_sel(i3),
    .reg_src_sel(src), .out0_sel(s0), .out1_sel(s1), .casc_op(op), .casc_use(uc),
    .lut_mask(msk), .operand_a_in(a), .operand_b_in(b), .third_data_in(d3),
    .fourth_data_in(d4), .group_carry_in(gci), .group_casc_in(gcsi), .group_carry_out(gco),
    .group_casc_out(gcso), .lut_comb(lut), .reg_q(rq), .out0(o0), .out1(o1));

  task automatic check(input logic [N-1:0] seen, input logic [N-1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("mismatches %0d of %0d compares", bad_count, total_checks);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  initial
  begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  // Drive 1 ns after each edge; note what must show this cycle
  initial
  begin
    srst = 1'h1;
    {clr, ena, ar, i3, src, s0, s1, op, uc, a, b, d3, d4, msk, cin, csin} = '0;
    nd = '0;
    void'($urandom(78));
    repeat (3) @(posedge core_clk);
    for (int t = 0; t < 400; t++)
    begin
      #1;
      ereg = nd;
      srst = ($urandom % 40) == 0;
      for (int k = 0; k < N; k++)
      begin
        {ar[k], i3[k], src[k], s0[k], s1[k], op[k], uc[k], a[k], b[k], d3[k], d4[k], ena[k]}
          = 12'($urandom);
        clr[k] = ($urandom % 16) == 0;
        msk[k*16+:16] = ($urandom % 2) ? 16'hE896 : 16'($urandom);
      end
      {cin, csin} = 4'($urandom);
      // Even and odd chains each skip a cluster
      for (int p = 0; p < 2; p++)
      begin
        c = cin[p];
        s = csin[p];
        for (int k = p; k < CL; k += 2)
          for (int i = 0; i < CE; i++)
          begin
            j = k * CE + i;
            m = msk[j*16+:16];
            x = {c, b[j], a[j]};
            el[j] = ar[j] ? m[x] : m[{d4[j], i3[j] ? c : d3[j], b[j], a[j]}];
            c = ar[j] ? m[8+x] : c;
            s = uc[j] ? (op[j] ? (s | el[j]) : (s & el[j])) : el[j];
          end
        eco[p] = c;
        ecs[p] = s;
      end
      ereg = ereg & ~clr;
      nd = srst ? '0 : ~clr & ((~ena & ereg) | (ena & ((src & d4) | (~src & el))));
      q.push_back('{el, ereg, (s0 & ereg) | (~s0 & el), (s1 & ereg) | (~s1 & el), eco, ecs});
      @(posedge core_clk);
    end
    // Let the watcher take the last note before the verdict
    repeat (2) @(negedge core_clk);
    conclude();
  end

  // Oldest note against the settled outputs mid-cycle
  always @(negedge core_clk)
    if (q.size() > 0)
    begin
      n = q.pop_front();
      check(lut, n.lut);
      check(rq, n.r);
      check(o0, n.o0);
      check(o1, n.o1);
      check(N'(gco), N'(n.co));
      check(N'(gcso), N'(n.cs));
    end

  // About 400 cycles expected; ten times that is a hang
  initial
  begin
    #(4000 * 100);
    bad_count++;
    conclude();
  end
endmodule : lcc_cluster_group_test
